// File: bcpr_pkg.sv
package bcpr_pkg;

    localparam int unsigned APB_AW = 12;
    localparam int unsigned DATA_W = 32;

    // Register byte addresses
    localparam logic [APB_AW-1:0] BOARD_COMMAND_OFS  = 12'h000;
    localparam logic [APB_AW-1:0] POWER_STATUS_OFS   = 12'h004;
    localparam logic [APB_AW-1:0] BOARD_CONFIG_OFS   = 12'h008;
    localparam logic [APB_AW-1:0] IRQ_LINE_RPT_OFS   = 12'h8fc;

    // Command codes
    localparam logic [DATA_W-1:0] BOARD_RESET_COMMAND = 32'h0000_0000;
    localparam logic [DATA_W-1:0] LOW_POWER_COMMAND   = 32'h0000_001e;

    // Reset values
    localparam logic [DATA_W-1:0] BOARD_COMMAND_RST = 32'h0000_0000;
    localparam logic [DATA_W-1:0] BOARD_CONFIG_RST  = 32'h0000_0001;
    localparam logic [DATA_W-1:0] IRQ_LINE_RST      = 32'h0000_0000;

    // Status field positions
    localparam int unsigned STAT_LOW_POWER_BIT = 0;
    localparam int unsigned STAT_MEM_VALID_BIT = 1;
    localparam int unsigned STAT_RST_BUSY_BIT  = 2;

    localparam int unsigned IRQ_LINE_W = 8;

    // Board hardware reset pulse length
    localparam int unsigned CLK_MHZ        = 40;
    localparam int unsigned HW_RST_NS      = 200;
    localparam int unsigned HW_RST_CYCLES  = (HW_RST_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned HW_RST_CNT_W   = 4;

    typedef enum logic [1:0] {
        BCPR_NORMAL    = 2'b00,
        BCPR_LOW_POWER = 2'b01,
        BCPR_RESETTING = 2'b10
    } bcpr_state_e;

    typedef enum logic [2:0] {
        BCPR_REG_COMMAND = 3'b000,
        BCPR_REG_STATUS  = 3'b001,
        BCPR_REG_CONFIG  = 3'b010,
        BCPR_REG_IRQLINE = 3'b011,
        BCPR_REG_NONE    = 3'b111
    } bcpr_reg_e;

endpackage

// File: bcpr_addr_decode.sv
`timescale 1ns/1ps
module bcpr_addr_decode
    import bcpr_pkg::*;
(
    input  wire logic [APB_AW-1:0] paddr,
    output bcpr_reg_e              regSel,
    output logic                   regWritable
);

    function automatic bcpr_reg_e decodeAddr(input logic [APB_AW-1:0] addr);
        case (addr)
            BOARD_COMMAND_OFS: decodeAddr = BCPR_REG_COMMAND;
            POWER_STATUS_OFS:  decodeAddr = BCPR_REG_STATUS;
            BOARD_CONFIG_OFS:  decodeAddr = BCPR_REG_CONFIG;
            IRQ_LINE_RPT_OFS:  decodeAddr = BCPR_REG_IRQLINE;
            default:           decodeAddr = BCPR_REG_NONE;
        endcase
    endfunction

    always_comb begin
        regSel      = decodeAddr(paddr);
        regWritable = (regSel == BCPR_REG_COMMAND) || (regSel == BCPR_REG_CONFIG);
    end

endmodule // bcpr_addr_decode

// File: bcpr_rst_stretch.sv
`timescale 1ns/1ps
module bcpr_rst_stretch
    import bcpr_pkg::*;
(
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic trigger,
    output logic      busy
);

    logic [HW_RST_CNT_W-1:0] cnt_reg;
    logic [HW_RST_CNT_W-1:0] cnt_next;

    // A new trigger restarts the full pulse length
    always_comb begin
        cnt_next = cnt_reg;
        if (trigger) begin
            cnt_next = HW_RST_CNT_W'(HW_RST_CYCLES);
        end else if (cnt_reg != '0) begin
            cnt_next = cnt_reg - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    assign busy = (cnt_reg != '0);

endmodule // bcpr_rst_stretch

// File: bcpr_board_command.sv
// Operation
// R1: Read/write command register at offset zero
// R2: Code 30 enters low-power mode
// R3: Low power gates clock and acquisition path
// R4: Low-power entry invalidates on-board memory
// R5: Reset command or board start leaves low power
// R6: Code 0 does software and hardware reset
// R7: Reset command restores configuration defaults
// R8: Reset command invalidates on-board memory
// R9: Read-only register reports assigned interrupt line
// R10: Repeated low-power command keeps low power only
`timescale 1ns/1ps
module bcpr_board_command
    import bcpr_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [APB_AW-1:0]     paddr,
    input  wire logic [DATA_W-1:0]     pwdata,
    output logic      [DATA_W-1:0]     prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  boardStart,
    input  wire logic                  acqDone,
    input  wire logic [IRQ_LINE_W-1:0] irqLineIn,
    output logic                       lowPowerMode,
    output logic                       acqClkEn,
    output logic                       acqPathEn,
    output logic                       memValid,
    output logic                       memReadEn,
    output logic                       swResetPulse,
    output logic                       hwResetOut,
    output logic      [DATA_W-1:0]     boardConfig
);

    bcpr_reg_e regSel;
    logic      regWritable;
    logic      stretchBusy;

    bcpr_addr_decode u_decode (
        .paddr       (paddr),
        .regSel      (regSel),
        .regWritable (regWritable)
    );

    // APB group
    logic [DATA_W-1:0] prdata_reg;
    logic [DATA_W-1:0] prdata_next;
    logic              pready_reg;
    logic              pready_next;
    logic              pslverr_reg;
    logic              pslverr_next;
    logic              wrTake;
    logic              cmdWrite;
    logic              cfgWrite;

    // Power / command group
    bcpr_state_e       state_reg;
    bcpr_state_e       state_next;
    logic [DATA_W-1:0] command_reg;
    logic [DATA_W-1:0] command_next;
    logic [DATA_W-1:0] config_reg;
    logic [DATA_W-1:0] config_next;
    logic              memValid_reg;
    logic              memValid_next;
    logic              swReset_reg;
    logic              swReset_next;
    logic              hwReset_reg;
    logic              hwReset_next;
    logic              lowPower_reg;
    logic              lowPower_next;
    logic              clkEn_reg;
    logic              clkEn_next;
    logic              pathEn_reg;
    logic              pathEn_next;
    logic              memRead_reg;
    logic              memRead_next;
    logic [DATA_W-1:0] irqLine_reg;
    logic [DATA_W-1:0] irqLine_next;
    logic              resetCmd;
    logic              lowPowerCmd;

    function automatic logic [DATA_W-1:0] statusWord(
        input bcpr_state_e st,
        input logic        valid,
        input logic        busy
    );
        logic [DATA_W-1:0] w;
        w                     = '0;
        w[STAT_LOW_POWER_BIT] = (st == BCPR_LOW_POWER);
        w[STAT_MEM_VALID_BIT] = valid;
        w[STAT_RST_BUSY_BIT]  = busy;
        statusWord            = w;
    endfunction

    // A code that differs from a command in any bit is only stored, never acted upon
    function automatic logic cmdMatch(
        input logic              wr,
        input logic [DATA_W-1:0] data,
        input logic [DATA_W-1:0] code
    );
        cmdMatch = wr && (data == code);
    endfunction

    // Acquisition clock, path and memory read-out run only in normal mode
    function automatic logic runsAcq(input bcpr_state_e st);
        runsAcq = (st == BCPR_NORMAL);
    endfunction

    // Access phase lasts two cycles: pready is raised one cycle after penable
    always_comb begin
        pready_next  = psel && penable && !pready_reg;
        prdata_next  = prdata_reg;
        pslverr_next = 1'b0;
        wrTake       = psel && penable && pready_reg && pwrite && !pslverr_reg;
        cmdWrite     = wrTake && (regSel == BCPR_REG_COMMAND);  // [R1]
        cfgWrite     = wrTake && (regSel == BCPR_REG_CONFIG);
        if (pready_next) begin
            // Unmapped addresses and writes to read-only words answer with an error
            pslverr_next = (regSel == BCPR_REG_NONE) || (pwrite && !regWritable);
            if (pwrite) begin
                prdata_next = '0;
            end else begin
                case (regSel)
                    BCPR_REG_COMMAND: prdata_next = command_reg;  // [R1]
                    BCPR_REG_STATUS:  prdata_next = statusWord(state_reg, memValid_reg,
                                                               stretchBusy);
                    BCPR_REG_CONFIG:  prdata_next = config_reg;
                    BCPR_REG_IRQLINE: prdata_next = irqLine_reg;  // [R9]
                    default:          prdata_next = '0;
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prdata_reg  <= '0;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            prdata_reg  <= prdata_next;
            pready_reg  <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    // Hardware reset line is held for a fixed time after the command
    bcpr_rst_stretch u_stretch (
        .clk     (clk),
        .sys_rst (sys_rst),
        .trigger (swReset_next),
        .busy    (stretchBusy)
    );

    // Command decode: only an exact whole-word match is acted upon
    always_comb begin
        resetCmd    = cmdMatch(cmdWrite, pwdata, BOARD_RESET_COMMAND);  // [R6]
        lowPowerCmd = cmdMatch(cmdWrite, pwdata, LOW_POWER_COMMAND);  // [R2]
    end

    // Power state group
    always_comb begin
        state_next    = state_reg;
        memValid_next = memValid_reg;
        swReset_next  = 1'b0;

        // Memory stays invalid from power-up until the first acquisition completes
        // Only a completed acquisition in normal mode makes memory valid
        if (acqDone && runsAcq(state_reg)) begin
            memValid_next = 1'b1;
        end

        case (state_reg)
            BCPR_NORMAL: begin
                if (lowPowerCmd) begin
                    state_next = BCPR_LOW_POWER;  // [R2]
                end
            end
            BCPR_LOW_POWER: begin
                // A second low-power command changes nothing here
                if (lowPowerCmd) begin
                    state_next = BCPR_LOW_POWER;  // [R10]
                end else if (boardStart) begin
                    state_next = BCPR_NORMAL;  // [R5]
                end
            end
            BCPR_RESETTING: begin
                if (lowPowerCmd) begin
                    state_next = BCPR_LOW_POWER;  // [R2]
                end else if (!stretchBusy) begin
                    state_next = BCPR_NORMAL;
                end
            end
            default: begin
                state_next = BCPR_NORMAL;
            end
        endcase

        // Invalidation beats a same-cycle acquisition completion: stale data must not survive
        if (lowPowerCmd) begin
            memValid_next = 1'b0;  // [R4]
        end

        // Reset command has top priority in every state
        if (resetCmd) begin
            state_next    = BCPR_RESETTING;  // [R5] [R6]
            swReset_next  = 1'b1;  // [R6]
            memValid_next = 1'b0;  // [R8]
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg    <= BCPR_NORMAL;
            memValid_reg <= 1'b0;
            swReset_reg  <= 1'b0;
        end else begin
            state_reg    <= state_next;
            memValid_reg <= memValid_next;
            swReset_reg  <= swReset_next;
        end
    end

    // Software-visible register group
    always_comb begin
        command_next = cmdWrite ? pwdata : command_reg;  // [R1]
        config_next  = cfgWrite ? pwdata : config_reg;
        // Codes without an action are still kept so software can read them back
        if (resetCmd) begin
            config_next  = BOARD_CONFIG_RST;  // [R7]
            command_next = BOARD_COMMAND_RST;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            command_reg <= BOARD_COMMAND_RST;
            config_reg  <= BOARD_CONFIG_RST;
        end else begin
            command_reg <= command_next;
            config_reg  <= config_next;
        end
    end

    // Side outputs follow the next state so every enable changes with the mode
    always_comb begin
        lowPower_next = (state_next == BCPR_LOW_POWER);
        clkEn_next    = runsAcq(state_next);  // [R3]
        pathEn_next   = runsAcq(state_next);  // [R3]
        memRead_next  = memValid_next && runsAcq(state_next);  // [R4] [R8]
        // A command during the stretch restarts it, so the line never drops between resets
        hwReset_next  = swReset_next || stretchBusy;  // [R6]
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            hwReset_reg  <= 1'b0;
            lowPower_reg <= 1'b0;
            clkEn_reg    <= 1'b1;
            pathEn_reg   <= 1'b1;
            memRead_reg  <= 1'b0;
        end else begin
            hwReset_reg  <= hwReset_next;
            lowPower_reg <= lowPower_next;
            clkEn_reg    <= clkEn_next;
            pathEn_reg   <= pathEn_next;
            memRead_reg  <= memRead_next;
        end
    end

    // Interrupt line group: sampled every clock, so reads see it one cycle late
    always_comb begin
        irqLine_next = {{(DATA_W-IRQ_LINE_W){1'b0}}, irqLineIn};  // [R9]
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irqLine_reg <= IRQ_LINE_RST;
        end else begin
            irqLine_reg <= irqLine_next;
        end
    end

    assign prdata       = prdata_reg;
    assign pready       = pready_reg;
    assign pslverr      = pslverr_reg;
    assign lowPowerMode = lowPower_reg;
    assign acqClkEn     = clkEn_reg;
    assign acqPathEn    = pathEn_reg;
    assign memValid     = memValid_reg;
    assign memReadEn    = memRead_reg;
    assign swResetPulse = swReset_reg;
    assign hwResetOut   = hwReset_reg;
    assign boardConfig  = config_reg;

endmodule // bcpr_board_command

// File: bcpr_host_model.sv
`timescale 1ns/1ps
module bcpr_host_model
    import bcpr_pkg::*;
(
    input  wire logic              clk,
    output logic                   psel,
    output logic                   penable,
    output logic                   pwrite,
    output logic      [APB_AW-1:0] paddr,
    output logic      [DATA_W-1:0] pwdata,
    input  wire logic [DATA_W-1:0] prdata,
    input  wire logic              pready,
    input  wire logic              pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
    end

    // Idle address and data are inverted so nothing stale looks like a request
    task automatic xfer(input logic w, input logic [APB_AW-1:0] a, input logic [DATA_W-1:0] d,
                        output logic [DATA_W-1:0] r, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule // bcpr_host_model

// File: bcpr_board_command_chk.sv
`timescale 1ns/1ps
module bcpr_board_command_chk
    import bcpr_pkg::*;
(
    input wire logic              clk,
    input wire logic              sys_rst,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              boardStart,
    input wire logic              lowPowerMode,
    input wire logic              acqClkEn,
    input wire logic              acqPathEn,
    input wire logic              memValid,
    input wire logic              memReadEn,
    input wire logic              swResetPulse,
    input wire logic              hwResetOut,
    input wire logic [DATA_W-1:0] boardConfig
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic cmdWr;
    logic lpWr;
    assign cmdWr = psel && penable && pwrite && pready && paddr == BOARD_COMMAND_OFS;
    assign lpWr = cmdWr && pwdata == LOW_POWER_COMMAND;

    AST_PREADY_PULSE: assert property (pready |=> !pready) else $error("pready too long");
    AST_PREADY_WAIT: assert property (psel && !penable |-> ##2 pready)
        else $error("pready late");
    AST_LP_ENTER: assert property (lpWr |-> ##[1:2] lowPowerMode) else $error("no low power");
    AST_LP_GATES: assert property (lowPowerMode |-> !acqClkEn && !acqPathEn)
        else $error("clock running in low power");
    AST_LP_MEM: assert property (lowPowerMode |-> !memValid && !memReadEn)
        else $error("memory valid in low power");
    AST_LP_HOLD: assert property (lowPowerMode && lpWr |-> ##1 lowPowerMode [*3])
        else $error("repeat low power left the mode");
    AST_LP_EXIT: assert property (lowPowerMode && boardStart && !cmdWr |-> ##[1:2] !lowPowerMode)
        else $error("start did not leave low power");
    AST_RST_CMD: assert property (cmdWr && pwdata == BOARD_RESET_COMMAND |->
        ##[1:2] swResetPulse ##[0:1] (boardConfig == BOARD_CONFIG_RST && !memValid))
        else $error("reset command incomplete");
    AST_SW_PULSE: assert property (swResetPulse |=> !swResetPulse) else $error("long sw reset");
    AST_HW_RST: assert property ($rose(swResetPulse) |-> ##[0:2] hwResetOut)
        else $error("no hardware reset");
    AST_RO_ERR: assert property (psel && penable && pready && pwrite &&
        paddr == IRQ_LINE_RPT_OFS |-> pslverr) else $error("read-only write accepted");

    cover property (lpWr);
    cover property ($fell(lowPowerMode));
    cover property (swResetPulse);
    cover property (lowPowerMode && hwResetOut);
endmodule // bcpr_board_command_chk

bind bcpr_board_command bcpr_board_command_chk i_chk (.clk, .sys_rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .pslverr, .boardStart, .lowPowerMode, .acqClkEn, .acqPathEn,
    .memValid, .memReadEn, .swResetPulse, .hwResetOut, .boardConfig);

// File: testbench.sv
`timescale 1ns/1ps
module testbench;
    import bcpr_pkg::*;
    logic                  clk = 1'b0, sysRst = 1'b1, boardStart = 1'b0, acqDone = 1'b0;
    logic [IRQ_LINE_W-1:0] irqLineIn = '0;
    logic                  psel, penable, pwrite, pready, pslverr, err;
    logic                  lowPowerMode, acqClkEn, acqPathEn, memValid, memReadEn;
    logic                  swResetPulse, hwResetOut;
    logic [APB_AW-1:0]     paddr;
    logic [DATA_W-1:0]     pwdata, prdata, boardConfig, rdVal, cfgExp, code;
    int                    fails = 0, num_checks = 0, seed = 32'hd0ed, hwCnt = 0, swCnt = 0;

    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        hwCnt <= hwCnt + int'(hwResetOut === 1'b1);
        swCnt <= swCnt + int'(swResetPulse === 1'b1);
    end

    bcpr_board_command i_dut (.clk, .sys_rst(sysRst), .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .boardStart, .acqDone, .irqLineIn, .lowPowerMode, .acqClkEn,
        .acqPathEn, .memValid, .memReadEn, .swResetPulse, .hwResetOut, .boardConfig);
    bcpr_host_model i_host (.clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr);

    function automatic logic [DATA_W-1:0] expStat(input logic lp, input logic mv, input logic bsy);
        return {29'h0, bsy, mv, lp};
    endfunction

    task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [APB_AW-1:0] a, input logic [DATA_W-1:0] d, input logic e);
        i_host.xfer(1'b1, a, d, rdVal, err);
        check(err, e);
    endtask

    task automatic rd(input logic [APB_AW-1:0] a, input logic [DATA_W-1:0] d, input logic e);
        i_host.xfer(1'b0, a, '0, rdVal, err);
        check(err, e);
        check(rdVal, d);
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        repeat (4000) @(posedge clk);
        fails++;
        finish_test();
    end

    initial begin
        repeat (12) @(posedge clk);
        sysRst <= 1'b0;
        check(boardConfig, BOARD_CONFIG_RST);
        rd(BOARD_COMMAND_OFS, BOARD_COMMAND_RST, 1'b0);
        for (int i = 0; i < 8; i++) begin
            cfgExp = $random(seed);
            code = $random(seed) | 32'h100;
            wr(BOARD_CONFIG_OFS, cfgExp, 1'b0);
            wr(BOARD_COMMAND_OFS, code, 1'b0);
            rd(BOARD_COMMAND_OFS, code, 1'b0);
            rd(BOARD_CONFIG_OFS, cfgExp, 1'b0);
        end
        irqLineIn <= IRQ_LINE_W'($random(seed));
        repeat (3) @(posedge clk);
        rd(IRQ_LINE_RPT_OFS, DATA_W'(irqLineIn), 1'b0);
        wr(IRQ_LINE_RPT_OFS, 32'h1, 1'b1);
        rd(12'h100, '0, 1'b1);
        acqDone <= 1'b1;
        @(posedge clk);
        acqDone <= 1'b0;
        rd(POWER_STATUS_OFS, expStat(1'b0, 1'b1, 1'b0), 1'b0);
        for (int k = 0; k < 2; k++) begin
            // Second pass repeats the command while already in low power
            wr(BOARD_COMMAND_OFS, LOW_POWER_COMMAND, 1'b0);
            repeat (2) @(posedge clk);
            check(lowPowerMode, 1'b1);
            check({acqClkEn, acqPathEn}, 2'b00);
            check({memValid, memReadEn}, 2'b00);
            rd(POWER_STATUS_OFS, expStat(1'b1, 1'b0, 1'b0), 1'b0);
        end
        boardStart <= 1'b1;
        @(posedge clk);
        boardStart <= 1'b0;
        repeat (3) @(posedge clk);
        check({lowPowerMode, acqClkEn}, 2'b01);
        wr(BOARD_COMMAND_OFS, LOW_POWER_COMMAND, 1'b0);
        wr(BOARD_CONFIG_OFS, 32'h5a5a_0f0f, 1'b0);
        wr(BOARD_COMMAND_OFS, BOARD_RESET_COMMAND, 1'b0);
        // Status is read while the board reset stretch is still running
        rd(POWER_STATUS_OFS, expStat(1'b0, 1'b0, 1'b1), 1'b0);
        for (int j = 0; j < 30 && hwResetOut !== 1'b0; j++) @(posedge clk);
        repeat (2) @(posedge clk);
        check(hwCnt, HW_RST_CYCLES + 1);
        check(swCnt, 1);
        check(lowPowerMode, 1'b0);
        rd(BOARD_CONFIG_OFS, BOARD_CONFIG_RST, 1'b0);
        rd(POWER_STATUS_OFS, expStat(1'b0, 1'b0, 1'b0), 1'b0);
        // Low-power command while the reset stretch runs
        wr(BOARD_COMMAND_OFS, BOARD_RESET_COMMAND, 1'b0);
        wr(BOARD_COMMAND_OFS, LOW_POWER_COMMAND, 1'b0);
        wr(BOARD_CONFIG_OFS, cfgExp, 1'b0);
        check({lowPowerMode, acqClkEn}, 2'b10);
        check(swCnt, 2);
        // Mid-run system reset
        sysRst <= 1'b1;
        repeat (2) @(posedge clk);
        sysRst <= 1'b0;
        check({lowPowerMode, acqClkEn, memValid, hwResetOut}, 4'b0100);
        check(boardConfig, BOARD_CONFIG_RST);
        rd(BOARD_COMMAND_OFS, BOARD_COMMAND_RST, 1'b0);
        finish_test();
    end
endmodule // testbench
